// *** ebpm_top.sv ***
// External bus pin multiplexer between static, SDRAM and NAND logic
// Function
// - Data bus configurable 16 or 32 bits
// - Address bus up to 26 bits
// - Six chip selects usable by static controller
// - Chip select one owned by SDRAM or static
// - NAND only through chip select three
// - Shared control pins muxed by active controller
// - SDRAM address lanes mapped onto port pins
// - NAND chip select active low
// - NAND read strobe active low
// - NAND write strobe active low
// - SDRAM chip select active low
// - Six devices, one space per select
// - Owner bit 0 static, 1 SDRAM
// - Select three bit enables NAND logic
// - Lane select picks NAND data lanes
`timescale 1ns/1ps
`default_nettype none
module ebpm_top #(
  parameter int DW = ebpm_pkg::DATA_W,
  parameter int AW = ebpm_pkg::ADDR_W,
  parameter int NC = ebpm_pkg::NUM_CS
) (
  // Clock and reset
  input  wire  logic                 SYS_CLK,
  input  wire  logic                 RST,
  // Configuration straps, synchronised inside
  input  wire  logic                 CS1_OWNER_SELECT,
  input  wire  logic                 CS3_NAND_ENABLE,
  input  wire  logic                 NAND_UPPER_LANE_SELECT,
  input  wire  logic                 BUS_WIDTH_32,
  // Static memory controller side
  input  wire  logic                 SMC_ACTIVE,
  input  wire  logic [AW-1:0]        SMC_ADDR,
  input  wire  logic [NC-1:0]        SMC_CS_N,
  input  wire  logic                 SMC_WRITE_STROBE_1_N,
  input  wire  logic [DW-1:0]        SMC_WDATA,
  input  wire  logic                 SMC_DATA_OE,
  input  wire  logic                 SMC_NAND_RD,
  input  wire  logic                 SMC_NAND_WR,
  output logic       [DW-1:0]        SMC_RDATA,
  // SDRAM controller side
  input  wire  logic                 SDR_ACTIVE,
  input  wire  logic [13:0]          SDR_ADDR,
  input  wire  logic                 SDR_CS_N,
  input  wire  logic                 SDR_BYTE_LANE_SELECT_1_N,
  input  wire  logic [DW-1:0]        SDR_WDATA,
  input  wire  logic                 SDR_DATA_OE,
  output logic       [DW-1:0]        SDR_RDATA,
  // NAND byte lanes
  input  wire  logic [15:0]          NAND_WDATA,
  input  wire  logic                 NAND_DATA_OE,
  output logic       [15:0]          NAND_RDATA,
  // External pins
  output logic       [AW-1:0]        EXT_ADDR,
  output logic                       EXT_SDRAM_ADDR10_LINE,
  output logic       [NC-1:0]        EXT_CHIP_SELECTS_N,
  output logic                       EXT_SDRAM_CHIP_SELECT_N,
  output logic                       EXT_NAND_CHIP_SELECT_N,
  output logic                       EXT_NAND_READ_STROBE_N,
  output logic                       EXT_NAND_WRITE_STROBE_N,
  output logic                       EXT_WR1_BS1_N,
  input  wire  logic [DW-1:0]        EXT_DATA_I,
  output logic       [DW-1:0]        EXT_DATA_O,
  output logic       [DW-1:0]        EXT_DATA_OE
);
  localparam int HW = ebpm_pkg::HALF_W;

  // Two-flop synchronisers for straps and data pins
  logic [3:0]    cfg_s1_q, cfg_s2_q;
  logic [DW-1:0] din_s1_q, din_s2_q;
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      cfg_s1_q <= {ebpm_pkg::RST_W32, ebpm_pkg::RST_LANE,
                   ebpm_pkg::RST_CS3_SEL, ebpm_pkg::RST_CS1_SEL};
      cfg_s2_q <= {ebpm_pkg::RST_W32, ebpm_pkg::RST_LANE,
                   ebpm_pkg::RST_CS3_SEL, ebpm_pkg::RST_CS1_SEL};
      din_s1_q <= '0;
      din_s2_q <= '0;
    end else begin
      cfg_s1_q <= {BUS_WIDTH_32, NAND_UPPER_LANE_SELECT,
                   CS3_NAND_ENABLE, CS1_OWNER_SELECT};
      cfg_s2_q <= cfg_s1_q;
      din_s1_q <= EXT_DATA_I;
      din_s2_q <= din_s1_q;
    end
  end
  logic cs1_sdram, cs3_nand, lane_hi, w32;
  assign cs1_sdram = (cfg_s2_q[0] == ebpm_pkg::CS1_SDRAM);
  assign cs3_nand  = (cfg_s2_q[1] == ebpm_pkg::CS3_NAND);
  assign lane_hi   = (cfg_s2_q[2] == ebpm_pkg::LANE_HIGH);
  assign w32       = cfg_s2_q[3];

  // Pick the controller that owns the shared pins
  function automatic ebpm_pkg::ebpm_owner_t owner_of(
    input logic static_mem_ctrl, input logic sdr, input logic nand_en);
    if (sdr)
      return ebpm_pkg::OWN_SDRAM;
    else if (static_mem_ctrl && nand_en)
      return ebpm_pkg::OWN_NAND;
    else if (static_mem_ctrl)
      return ebpm_pkg::OWN_STATIC;
    else
      return ebpm_pkg::OWN_NONE;
  endfunction : owner_of

  ebpm_pkg::ebpm_owner_t owner_d, owner_q;
  logic nand_sel;
  assign nand_sel = cs3_nand && !SMC_CS_N[ebpm_pkg::CS_NAND_IDX];

  // Registered pin values
  logic [AW-1:0] addr_d, addr_q;
  logic          a10_d, a10_q;
  logic [NC-1:0] cs_d, cs_q;
  logic          sdram_chip_select_d, sdram_chip_select_q, ncs_d, ncs_q, nre_d, nre_q, nwe_d, nwe_q;
  logic          wb1_d, wb1_q;
  logic [DW-1:0] dout_d, dout_q, doe_d, doe_q;

  always_comb begin
    owner_d = owner_of(SMC_ACTIVE, SDR_ACTIVE && cs1_sdram, nand_sel);
    addr_d  = '0;
    a10_d   = 1'h0;
    cs_d    = {NC{ebpm_pkg::PIN_IDLE}};
    sdram_chip_select_d  = ebpm_pkg::PIN_IDLE;
    ncs_d   = ebpm_pkg::PIN_IDLE;
    nre_d   = ebpm_pkg::PIN_IDLE;
    nwe_d   = ebpm_pkg::PIN_IDLE;
    wb1_d   = ebpm_pkg::PIN_IDLE;
    dout_d  = '0;
    doe_d   = '0;
    case (owner_d)
      ebpm_pkg::OWN_SDRAM: begin
        addr_d[11:2]  = SDR_ADDR[9:0];
        a10_d         = SDR_ADDR[10];
        addr_d[15:13] = SDR_ADDR[13:11];
        sdram_chip_select_d        = SDR_CS_N;
        cs_d[ebpm_pkg::CS_SDRAM_IDX] = SDR_CS_N;
        wb1_d         = SDR_BYTE_LANE_SELECT_1_N;
        dout_d        = SDR_WDATA;
        doe_d         = {DW{SDR_DATA_OE}};
      end
      ebpm_pkg::OWN_STATIC, ebpm_pkg::OWN_NAND: begin
        addr_d = SMC_ADDR;
        cs_d   = SMC_CS_N;
        if (cs1_sdram)
          cs_d[ebpm_pkg::CS_SDRAM_IDX] = ebpm_pkg::PIN_IDLE;
        wb1_d  = SMC_WRITE_STROBE_1_N;
        dout_d = SMC_WDATA;
        doe_d  = {DW{SMC_DATA_OE}};
        if (owner_d == ebpm_pkg::OWN_NAND) begin
          ncs_d = 1'h0;
          nre_d = !SMC_NAND_RD;
          nwe_d = !SMC_NAND_WR;
          doe_d = '0;
          if (lane_hi) begin
            dout_d[DW-1:HW] = NAND_WDATA;
            doe_d[DW-1:HW]  = {HW{NAND_DATA_OE}};
          end else begin
            dout_d[HW-1:0]  = NAND_WDATA;
            doe_d[HW-1:0]   = {HW{NAND_DATA_OE}};
          end
        end
      end
      default: begin
      end
    endcase
    // Upper lanes not driven in 16-bit mode, except by NAND on the upper lane
    if (!w32 && !(owner_d == ebpm_pkg::OWN_NAND && lane_hi))
      doe_d[DW-1:HW] = '0;
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      owner_q <= ebpm_pkg::OWN_NONE;
      addr_q  <= '0;
      a10_q   <= 1'h0;
      cs_q    <= {NC{ebpm_pkg::PIN_IDLE}};
      sdram_chip_select_q  <= ebpm_pkg::PIN_IDLE;
      ncs_q   <= ebpm_pkg::PIN_IDLE;
      nre_q   <= ebpm_pkg::PIN_IDLE;
      nwe_q   <= ebpm_pkg::PIN_IDLE;
      wb1_q   <= ebpm_pkg::PIN_IDLE;
      dout_q  <= '0;
      doe_q   <= '0;
    end else begin
      owner_q <= owner_d;
      addr_q  <= addr_d;
      a10_q   <= a10_d;
      cs_q    <= cs_d;
      sdram_chip_select_q  <= sdram_chip_select_d;
      ncs_q   <= ncs_d;
      nre_q   <= nre_d;
      nwe_q   <= nwe_d;
      wb1_q   <= wb1_d;
      dout_q  <= dout_d;
      doe_q   <= doe_d;
    end
  end

  assign EXT_ADDR                = addr_q;
  assign EXT_SDRAM_ADDR10_LINE   = a10_q;
  assign EXT_CHIP_SELECTS_N      = cs_q;
  assign EXT_SDRAM_CHIP_SELECT_N = sdram_chip_select_q;
  assign EXT_NAND_CHIP_SELECT_N  = ncs_q;
  assign EXT_NAND_READ_STROBE_N  = nre_q;
  assign EXT_NAND_WRITE_STROBE_N = nwe_q;
  assign EXT_WR1_BS1_N           = wb1_q;
  assign EXT_DATA_O              = dout_q;
  assign EXT_DATA_OE             = doe_q;

  // Read data: synchronised pins; 16-bit mode masks upper lanes of static and SDRAM read data
  assign SMC_RDATA  = w32 ? din_s2_q : {{HW{1'h0}}, din_s2_q[HW-1:0]};
  assign SDR_RDATA  = SMC_RDATA;
  assign NAND_RDATA = lane_hi ? din_s2_q[DW-1:HW] : din_s2_q[HW-1:0];

  // Checks
  chk_sdram_cs_follow: assert property (@(posedge SYS_CLK) disable iff (RST)
    (SDR_ACTIVE && cs1_sdram) |=> EXT_SDRAM_CHIP_SELECT_N == $past(SDR_CS_N))
    else $error("sdram select not routed");
  chk_cs1_smc_block: assert property (@(posedge SYS_CLK) disable iff (RST)
    (!SDR_ACTIVE && cs1_sdram) |=> EXT_CHIP_SELECTS_N[1] == 1'h1)
    else $error("cs1 driven by static while owned by sdram");
  chk_nand_cs_low: assert property (@(posedge SYS_CLK) disable iff (RST)
    (!SDR_ACTIVE && SMC_ACTIVE && nand_sel) |=> !EXT_NAND_CHIP_SELECT_N)
    else $error("nand select not asserted");
  chk_nand_only_cs3: assert property (@(posedge SYS_CLK) disable iff (RST)
    !cs3_nand |=> EXT_NAND_CHIP_SELECT_N)
    else $error("nand select without cs3 enable");
  chk_nand_rd_strobe: assert property (@(posedge SYS_CLK) disable iff (RST)
    (owner_d == ebpm_pkg::OWN_NAND && SMC_NAND_RD) |=>
      !EXT_NAND_READ_STROBE_N)
    else $error("nand read strobe not low");
  chk_nand_wr_strobe: assert property (@(posedge SYS_CLK) disable iff (RST)
    (owner_d != ebpm_pkg::OWN_NAND) |=> EXT_NAND_WRITE_STROBE_N)
    else $error("nand write strobe outside nand");
  chk_sdram_addr_map: assert property (@(posedge SYS_CLK) disable iff (RST)
    (SDR_ACTIVE && cs1_sdram) |=>
      EXT_ADDR[11:2] == $past(SDR_ADDR[9:0]) &&
      EXT_SDRAM_ADDR10_LINE == $past(SDR_ADDR[10]) &&
      EXT_ADDR[15:13] == $past(SDR_ADDR[13:11]) &&
      EXT_ADDR[1:0] == 2'h0 && EXT_ADDR[12] == 1'h0)
    else $error("sdram address lanes misrouted");
  chk_idle_pins: assert property (@(posedge SYS_CLK) disable iff (RST)
    (!SMC_ACTIVE && !SDR_ACTIVE) |=>
      EXT_CHIP_SELECTS_N == {NC{1'h1}} && EXT_DATA_OE == '0)
    else $error("pins not idle");
  chk_width16_oe: assert property (@(posedge SYS_CLK) disable iff (RST)
    (!w32 && owner_d != ebpm_pkg::OWN_NAND) |=>
      EXT_DATA_OE[DW-1:HW] == '0)
    else $error("upper lanes driven in 16-bit mode");
  chk_nand_lane: assert property (@(posedge SYS_CLK) disable iff (RST)
    (owner_d == ebpm_pkg::OWN_NAND && lane_hi) |=>
      EXT_DATA_OE[HW-1:0] == '0)
    else $error("nand lane select ignored");

  // Straps settle through two flops before they steer any pin
  sequence seq_cs1_to_sdram;
    CS1_OWNER_SELECT ##1 CS1_OWNER_SELECT;
  endsequence
  sequence seq_cs1_to_static;
    !CS1_OWNER_SELECT ##1 !CS1_OWNER_SELECT;
  endsequence
  sequence seq_cs3_to_nand;
    CS3_NAND_ENABLE ##1 CS3_NAND_ENABLE;
  endsequence
  chk_cs1_strap_set: assert property (@(posedge SYS_CLK) disable iff (RST)
    seq_cs1_to_sdram |=> cs1_sdram)
    else $error("cs1 owner strap not taken");
  chk_cs1_strap_clr: assert property (@(posedge SYS_CLK) disable iff (RST)
    seq_cs1_to_static |=> !cs1_sdram)
    else $error("cs1 owner strap not released");
  chk_cs3_strap_set: assert property (@(posedge SYS_CLK) disable iff (RST)
    seq_cs3_to_nand |=> cs3_nand)
    else $error("cs3 nand strap not taken");
  // Registered owner and NAND select are launched by the same edge
  chk_owner_nand_pin: assert property (@(posedge SYS_CLK) disable iff (RST)
    EXT_NAND_CHIP_SELECT_N == (owner_q != ebpm_pkg::OWN_NAND))
    else $error("nand select disagrees with owner");
  chk_nand_wr_low: assert property (@(posedge SYS_CLK) disable iff (RST)
    (owner_d == ebpm_pkg::OWN_NAND && SMC_NAND_WR) |=>
      !EXT_NAND_WRITE_STROBE_N)
    else $error("nand write strobe not low");
  chk_nand_rd_idle: assert property (@(posedge SYS_CLK) disable iff (RST)
    (owner_d != ebpm_pkg::OWN_NAND) |=> EXT_NAND_READ_STROBE_N)
    else $error("nand read strobe outside nand");
  chk_static_addr: assert property (@(posedge SYS_CLK) disable iff (RST)
    (SMC_ACTIVE && !(SDR_ACTIVE && cs1_sdram)) |=>
      EXT_ADDR == $past(SMC_ADDR))
    else $error("static address not routed");
  chk_static_cs: assert property (@(posedge SYS_CLK) disable iff (RST)
    (SMC_ACTIVE && !cs1_sdram) |=>
      EXT_CHIP_SELECTS_N == $past(SMC_CS_N))
    else $error("static selects not routed");
  chk_sdram_cs1_mirror: assert property (@(posedge SYS_CLK) disable iff (RST)
    (SDR_ACTIVE && cs1_sdram) |=>
      EXT_CHIP_SELECTS_N[1] == $past(SDR_CS_N) &&
      EXT_CHIP_SELECTS_N[0] && (&EXT_CHIP_SELECTS_N[NC-1:2]))
    else $error("cs1 not mirroring sdram select");
  chk_sdram_sel_idle: assert property (@(posedge SYS_CLK) disable iff (RST)
    !(SDR_ACTIVE && cs1_sdram) |=> EXT_SDRAM_CHIP_SELECT_N)
    else $error("sdram select active without sdram");
  // One pin carries both strobes, so its source must follow the owner
  chk_bs1_sdram: assert property (@(posedge SYS_CLK) disable iff (RST)
    (SDR_ACTIVE && cs1_sdram) |=>
      EXT_WR1_BS1_N == $past(SDR_BYTE_LANE_SELECT_1_N))
    else $error("shared pin not carrying sdram byte select");
  chk_wr1_static: assert property (@(posedge SYS_CLK) disable iff (RST)
    (SMC_ACTIVE && !(SDR_ACTIVE && cs1_sdram)) |=>
      EXT_WR1_BS1_N == $past(SMC_WRITE_STROBE_1_N))
    else $error("shared pin not carrying static write");
  chk_nand_upper_data: assert property (@(posedge SYS_CLK) disable iff (RST)
    (owner_d == ebpm_pkg::OWN_NAND && lane_hi) |=>
      EXT_DATA_O[DW-1:HW] == $past(NAND_WDATA))
    else $error("nand data missing on upper lanes");
  chk_nand_lower_data: assert property (@(posedge SYS_CLK) disable iff (RST)
    (owner_d == ebpm_pkg::OWN_NAND && !lane_hi) |=>
      EXT_DATA_O[HW-1:0] == $past(NAND_WDATA))
    else $error("nand data missing on lower lanes");
endmodule : ebpm_top
`default_nettype wire

// *** ebpm_pkg.sv ***
// Constants for the external bus pin multiplexer
package ebpm_pkg;
  localparam int DATA_W        = 32;
  localparam int HALF_W        = 16;
  localparam int ADDR_W        = 26;
  localparam int NUM_CS        = 6;
  localparam int SD_ADDR_W     = 14;
  localparam int CS_SDRAM_IDX  = 1;
  localparam int CS_NAND_IDX   = 3;
  localparam logic CS1_SMC     = 1'h0;
  localparam logic CS1_SDRAM   = 1'h1;
  localparam logic CS3_PLAIN   = 1'h0;
  localparam logic CS3_NAND    = 1'h1;
  localparam logic LANE_LOW    = 1'h0;
  localparam logic LANE_HIGH   = 1'h1;
  localparam logic PIN_IDLE    = 1'h1;
  localparam logic RST_CS1_SEL = 1'h0;
  localparam logic RST_CS3_SEL = 1'h0;
  localparam logic RST_LANE    = 1'h0;
  localparam logic RST_W32     = 1'h1;
  typedef enum logic [1:0] {OWN_NONE, OWN_STATIC, OWN_SDRAM, OWN_NAND}
    ebpm_owner_t;
endpackage : ebpm_pkg

// *** ebpm_mem_model.sv ***
// Behavioural external memory answering on the shared data pins
`timescale 1ns/1ps
`default_nettype none
module ebpm_mem_model (
  // Pins from the port
  input  wire logic        clk,
  input  wire logic [25:0] addr,
  input  wire logic [5:0]  cs_n,
  input  wire logic        sd_cs_n,
  input  wire logic [31:0] oe,
  // Data back to the port
  output logic      [31:0] dq
);
  logic [31:0] last_q = 32'h0;
  // Released lines flip each cycle so stale data never looks valid
  always @(posedge clk) begin
    last_q <= dq;
  end
  assign dq = ((!(&cs_n) || !sd_cs_n) && oe == 32'h0) ?
    {~addr[15:0], addr[15:0]} : ~last_q;
endmodule : ebpm_mem_model
`default_nettype wire

// *** ebpm_top_tb.sv ***
// Self-checking bench for the external bus pin multiplexer
`timescale 1ns/1ps
`default_nettype none
module ebpm_top_tb;
  logic        clk = 1'h0, rst = 1'h1, own = 1'h0, nen = 1'h0, lane = 1'h0;
  logic        w32 = 1'h1, s_act = 1'h0, s_wr1 = 1'h1, s_oe = 1'h0;
  logic        s_rd = 1'h0, s_wr = 1'h0, n_oe = 1'h0, d_act = 1'h0;
  logic        d_cs = 1'h1, d_bs1 = 1'h1, d_oe = 1'h0;
  logic [25:0] s_addr = 26'h0, addr;
  logic [5:0]  s_cs = 6'h3F, cs_n;
  logic [13:0] d_addr = 14'h0;
  logic [15:0] n_wd = 16'h0, n_rd;
  logic [31:0] s_wd = 32'h0, d_wd = 32'h0, s_rdat, d_rdat, dout, doe, din;
  logic        a10, sdram_chip_select, ncs, nrd, nwr, wr1;
  int          miscompares = 0;
  int          cmp_count = 0;
  always #2.5 clk = ~clk;
  ebpm_top ebpm_top_inst (
    .SYS_CLK(clk), .RST(rst), .CS1_OWNER_SELECT(own),
    .CS3_NAND_ENABLE(nen), .NAND_UPPER_LANE_SELECT(lane), .BUS_WIDTH_32(w32),
    .SMC_ACTIVE(s_act), .SMC_ADDR(s_addr), .SMC_CS_N(s_cs),
    .SMC_WRITE_STROBE_1_N(s_wr1), .SMC_WDATA(s_wd), .SMC_DATA_OE(s_oe),
    .SMC_NAND_RD(s_rd), .SMC_NAND_WR(s_wr), .SMC_RDATA(s_rdat),
    .SDR_ACTIVE(d_act), .SDR_ADDR(d_addr), .SDR_CS_N(d_cs),
    .SDR_BYTE_LANE_SELECT_1_N(d_bs1), .SDR_WDATA(d_wd), .SDR_DATA_OE(d_oe),
    .SDR_RDATA(d_rdat), .NAND_WDATA(n_wd), .NAND_DATA_OE(n_oe),
    .NAND_RDATA(n_rd), .EXT_ADDR(addr), .EXT_SDRAM_ADDR10_LINE(a10),
    .EXT_CHIP_SELECTS_N(cs_n), .EXT_SDRAM_CHIP_SELECT_N(sdram_chip_select),
    .EXT_NAND_CHIP_SELECT_N(ncs), .EXT_NAND_READ_STROBE_N(nrd),
    .EXT_NAND_WRITE_STROBE_N(nwr), .EXT_WR1_BS1_N(wr1),
    .EXT_DATA_I(din), .EXT_DATA_O(dout), .EXT_DATA_OE(doe));
  ebpm_mem_model ebpm_mem_model_inst (
    .clk(clk), .addr(addr), .cs_n(cs_n), .sd_cs_n(sdram_chip_select), .oe(doe), .dq(din));
  task automatic cmp(input logic [31:0] got, exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: %s", $time, what);
    end
  endtask : cmp
  // Let the edge's updates land before looking
  task automatic run(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : run
  task automatic report_and_stop;
    $display("compares %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  task automatic t_static;
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      {s_act, s_oe, s_wr1, s_cs} <= {2'h3, i[0], ~(6'h01 << i)};
      s_addr <= 26'h3FF_FFF0 | 26'(i);
      run(1);
      cmp({cs_n, addr}, {~(6'h01 << i), 26'h3FF_FFF0 | 26'(i)}, "sel");
      cmp({wr1, doe[30:0]}, {i[0], 31'h7FFF_FFFF}, "wr1 oe");
    end
    @(posedge clk);
    {s_oe, s_cs, s_addr, w32} <= {1'h0, 6'h3E, 26'h123_4567, 1'h0};
    run(6);
    cmp(s_rdat, 32'h0000_4567, "16-bit read");
    @(posedge clk);
    s_oe <= 1'h1;
    run(1);
    cmp(doe, 32'h0000_FFFF, "16-bit oe");
    @(posedge clk);
    {w32, s_act, s_oe} <= 3'h4;
  endtask : t_static
  task automatic t_sdram;
    @(posedge clk);
    {d_act, d_cs, d_bs1, d_oe, d_addr} <= {4'h9, 14'h2D5A};
    {d_wd, s_addr} <= {32'h1357_9BDF, 26'h3FF_FFFF};
    run(1);
    cmp({sdram_chip_select, cs_n, 25'h0}, {7'h7F, 25'h0}, "sdram refused");
    @(posedge clk);
    own <= 1'h1;
    run(4);
    cmp({sdram_chip_select, a10, wr1, cs_n, 23'h0}, {9'h0BD, 23'h0}, "sdram sel");
    cmp({6'h0, addr}, 32'h0000_A568, "sdram addr");
    cmp(dout, 32'h1357_9BDF, "sdram wdata");
    @(posedge clk);
    d_oe <= 1'h0;
    run(4);
    cmp(d_rdat, 32'h5A97_A568, "sdram read");
    @(posedge clk);
    {s_act, s_cs} <= {1'h1, 6'h3E};
    run(1);
    cmp({cs_n, addr}, {6'h3D, 26'h000_A568}, "sdram wins");
    @(posedge clk);
    {d_act, d_cs, s_act, s_cs} <= {3'h3, 6'h3D};
    run(1);
    cmp({26'h0, cs_n}, 32'h0000_003F, "cs1 blocked");
    @(posedge clk);
    {own, s_cs} <= {1'h0, 6'h37};
  endtask : t_sdram
  task automatic t_nand;
    @(posedge clk);
    {s_rd, s_addr} <= {1'h1, 26'h000_1234};
    run(1);
    cmp({ncs, nrd, cs_n, 24'h0}, {8'hF7, 24'h0}, "cs3 plain");
    @(posedge clk);
    nen <= 1'h1;
    run(4);
    cmp({ncs, nrd, nwr, cs_n, 23'h0}, {9'h077, 23'h0}, "nand sel");
    for (int l = 0; l < 2; l++) begin
      @(posedge clk);
      {lane, s_rd, s_wr, n_oe, n_wd} <= {l[0], 3'h3, 16'hB00F};
      run(4);
      cmp({31'h0, nwr}, 32'h0, "nand wr");
      cmp(doe, l ? 32'hFFFF_0000 : 32'h0000_FFFF, "lane oe");
      cmp(dout & doe, l ? 32'hB00F_0000 : 32'h0000_B00F, "lane data");
      @(posedge clk);
      {s_rd, s_wr, n_oe} <= 3'h4;
      run(4);
      cmp({15'h0, nrd, n_rd}, l ? 32'hEDCB : 32'h1234, "nand read");
    end
    @(posedge clk);
    s_cs <= 6'h3E;
    run(1);
    cmp({31'h0, ncs}, 32'h1, "nand off cs3");
  endtask : t_nand
  initial begin
    run(2);
    cmp({27'h0, ncs, nrd, nwr, sdram_chip_select, wr1}, 32'h1F, "reset strobes");
    cmp({cs_n, doe[25:0]}, 32'hFC00_0000, "reset pins");
    @(posedge clk);
    rst <= 1'h0;
    t_static();
    t_sdram();
    t_nand();
    report_and_stop();
  end
  // Whole run needs under a hundred cycles
  initial begin
    repeat (3000) @(posedge clk);
    miscompares++;
    report_and_stop();
  end
endmodule : ebpm_top_tb
`default_nettype wire
